// File: core/idle_mode_clock_controller_cfg.svh
`ifndef IDLE_MODE_CLOCK_CONTROLLER_CFG_SVH
`define IDLE_MODE_CLOCK_CONTROLLER_CFG_SVH

// register byte offsets
`define IMCC_OSC_CTRL_OFS   8'h00
`define IMCC_AUX_CTRL_OFS   8'h04
`define IMCC_MODE_OFS       8'h08

// oscillator_control_register fields
`define IMCC_IDLE_EN_BIT    7
`define IMCC_IFS_LSB        4
`define IMCC_PRI_FLAG_BIT   3
`define IMCC_INT_FLAG_BIT   2
`define IMCC_SCS_LSB        0

// auxiliary control register fields
`define IMCC_SEC_EN_BIT     0
`define IMCC_SEC_FLAG_BIT   1
`define IMCC_WDT_EN_BIT     2
`define IMCC_FSCM_EN_BIT    3

// reset values
`define IMCC_IDLE_RESET     1'b0
`define IMCC_SCS_RESET      2'h0
`define IMCC_IFS_RESET      3'h0

// timing
`define IMCC_CLK_PERIOD_NS  8
`define IMCC_WAKE_DELAY_NS  10000
`define IMCC_WAKE_CYCLES    ((`IMCC_WAKE_DELAY_NS + `IMCC_CLK_PERIOD_NS - 1) / `IMCC_CLK_PERIOD_NS)
`define IMCC_INT_STABLE_NS  1000000
`define IMCC_INT_STABLE_CYCLES \
   ((`IMCC_INT_STABLE_NS + `IMCC_CLK_PERIOD_NS - 1) / `IMCC_CLK_PERIOD_NS)
`define IMCC_SWITCH_EDGES   8

`endif

// File: core/idle_mode_clock_controller_pkg.sv
package idle_mode_clock_controller_pkg;

   typedef enum logic [2:0] {
      ST_RUN_PRI,
      ST_SWITCH,
      ST_SEC_WAIT,
      ST_IDLE,
      ST_WAKE_DELAY,
      ST_RUN_ALT,
      ST_SLEEP,
      ST_SLEEP_WAKE
   } pm_state_type;

   typedef enum logic [1:0] {
      SRC_PRI,
      SRC_SEC,
      SRC_INT
   } clk_src_type;

   typedef struct packed {
      pm_state_type st;
      clk_src_type  src;
      clk_src_type  target;
      logic [3:0]   edge_cnt;
      logic [10:0]  wait_cnt;
      logic [23:0]  stable_cnt;
      logic         idle_enable_bit;
      logic [2:0]   internal_freq_select;
      logic [1:0]   clock_source_select;
      logic         secondary_osc_enable;
      logic         wdt_enable;
      logic         fscm_enable;
      logic         primary_ready_flag;
      logic         internal_stable_flag;
      logic         secondary_active_flag;
      logic         int_stable;
      logic [4:0]   sync1;
      logic [4:0]   sync2;
      logic [2:0]   sync_prev;
      logic         ahb_wr;
      logic [5:0]   ahb_idx;
      logic [31:0]  rdata;
      logic         ready;
      logic         resp;
      logic         cpu_clk_en;
      logic         periph_clk_en;
      logic         pri_osc_en;
      logic         fast_osc_en;
      logic         slow_osc_en;
      logic         wdt_reset;
   } ctrl_state_type;

endpackage : idle_mode_clock_controller_pkg

// File: core/idle_mode_clock_controller.sv
// Our own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/10ps
`include "idle_mode_clock_controller_cfg.svh"

// Overview of operation
// RULE1 - idle enable plus power-down stops CPU clock, peripherals stay clocked
// RULE2 - all-zero idle enable and source select at power-down means full sleep
// RULE3 - idle enable at bit 7; peripherals run from selected source
// RULE4 - idle modes exit only on interrupt, watchdog time-out or reset
// RULE5 - after wake, CPU held off about 10 us before executing; code does so only from ST_IDLE, not from sleep or ST_SEC_WAIT
// RULE6 - CPU runs on idle source until primary ready, then switch back
// RULE7 - wake-up never alters idle enable or source select bits
// RULE8 - watchdog time-out in idle or sleep wakes instead of resetting
// RULE9 - primary idle keeps primary running and primary-ready flag set
// RULE10 - wake from primary idle: CPU on primary, primary-ready stays set
// RULE11 - secondary idle: peripherals on secondary, primary off, flags swap
// RULE12 - secondary idle with secondary oscillator disabled ignores power-down
// RULE13 - secondary not yet oscillating: peripheral clocks held until it starts
// RULE14 - wake from secondary idle: run secondary, then primary, flags swap back
// RULE15 - upper select bit set: internal idle, primary oscillator stops
// RULE16 - non-zero frequency select enables fast oscillator; stable flag after 1 ms
// RULE17 - already stable fast oscillator keeps internal-stable flag set
// RULE18 - zero frequency select keeps fast oscillator off and flag clear
// RULE19 - wake from internal idle: run internal, then primary, flags swap
// RULE20 - slow internal oscillator runs while watchdog or clock monitor enabled
// RULE21 - source select writes affect nothing until a power-down instruction
// RULE22 - each source switch pauses clocks eight to nine new-source periods; code counts eight edges, 7 to 8 periods
// RULE23 - status flags read-only; at most one set in power managed mode
module idle_mode_clock_controller #(
   parameter int unsigned INT_STABLE_CYCLES = `IMCC_INT_STABLE_CYCLES
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        clk_en,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        sleep_instr,
   input  wire logic        wake_irq,
   input  wire logic        wdt_timeout,
   input  wire logic        pri_osc_clk,
   input  wire logic        sec_osc_clk,
   input  wire logic        int_osc_clk,
   input  wire logic        pri_ready_pin,
   input  wire logic        sec_running_pin,
   output logic             cpu_clk_en,
   output logic             periph_clk_en,
   output logic [1:0]       sys_clk_sel,
   output logic             pri_osc_en,
   output logic             fast_internal_osc_en,
   output logic             slow_internal_osc_en,
   output logic             wdt_reset
);

   localparam logic [10:0] WAKE_LAST   = 11'(`IMCC_WAKE_CYCLES - 1);
   localparam logic [23:0] STABLE_LAST = 24'(INT_STABLE_CYCLES - 1);
   localparam logic [3:0]  EDGE_LAST   = 4'(`IMCC_SWITCH_EDGES - 1);
   localparam logic [5:0]  IDX_OSC     = 6'(`IMCC_OSC_CTRL_OFS >> 2);
   localparam logic [5:0]  IDX_AUX     = 6'(`IMCC_AUX_CTRL_OFS >> 2);
   localparam logic [5:0]  IDX_MODE    = 6'(`IMCC_MODE_OFS >> 2);

   idle_mode_clock_controller_pkg::ctrl_state_type s;
   idle_mode_clock_controller_pkg::ctrl_state_type n;

   // starts the pause before a source change; peripheral clocks resume on the new source, the CPU clock only on primary
   function automatic idle_mode_clock_controller_pkg::ctrl_state_type begin_switch(
      input idle_mode_clock_controller_pkg::ctrl_state_type cur,
      input idle_mode_clock_controller_pkg::clk_src_type    tgt
   );
      idle_mode_clock_controller_pkg::ctrl_state_type r;
      r               = cur;
      r.target        = tgt;
      r.edge_cnt      = 4'h0;
      r.cpu_clk_en    = 1'b0;
      r.periph_clk_en = 1'b0;
      r.st            = idle_mode_clock_controller_pkg::ST_SWITCH;
      return r;
   endfunction : begin_switch

   // register read mux; control and flags from next values so a write just before shows
   function automatic logic [31:0] read_word(
      input idle_mode_clock_controller_pkg::ctrl_state_type nxt,
      input idle_mode_clock_controller_pkg::ctrl_state_type cur,
      input logic [5:0]                                     idx
   );
      logic [31:0] w;
      w = 32'h0;
      if (idx == IDX_OSC)
      begin
         w[`IMCC_IDLE_EN_BIT]  = nxt.idle_enable_bit;
         w[`IMCC_IFS_LSB +: 3] = nxt.internal_freq_select;
         w[`IMCC_PRI_FLAG_BIT] = nxt.primary_ready_flag;
         w[`IMCC_INT_FLAG_BIT] = nxt.internal_stable_flag;
         w[`IMCC_SCS_LSB +: 2] = nxt.clock_source_select;
      end
      else if (idx == IDX_AUX)
      begin
         w[`IMCC_SEC_EN_BIT]   = nxt.secondary_osc_enable;
         w[`IMCC_SEC_FLAG_BIT] = nxt.secondary_active_flag;
         w[`IMCC_WDT_EN_BIT]   = nxt.wdt_enable;
         w[`IMCC_FSCM_EN_BIT]  = nxt.fscm_enable;
      end
      else if (idx == IDX_MODE)
         w[4:0] = {cur.src, cur.st};
      return w;
   endfunction : read_word

   logic [2:0] osc_edge;
   logic       wake_event;
   logic       addr_phase;

   always_comb
   begin
      n          = s;
      osc_edge   = s.sync2[2:0] & ~s.sync_prev;
      wake_event = wake_irq | wdt_timeout; // [RULE4] [RULE8]
      addr_phase = hsel & htrans[1] & hready;

      // pins cross into hclk through two flops; edges are taken off stage two
      n.sync1     = {sec_running_pin, pri_ready_pin, int_osc_clk, sec_osc_clk, pri_osc_clk};
      n.sync2     = s.sync1;
      n.sync_prev = s.sync2[2:0];
      n.wdt_reset = 1'b0;

      // data phase of a write; status flags have no write path [RULE23]
      if (s.ahb_wr)
      begin
         if (s.ahb_idx == IDX_OSC)
         begin
            n.idle_enable_bit      = hwdata[`IMCC_IDLE_EN_BIT]; // [RULE3]
            n.internal_freq_select = hwdata[`IMCC_IFS_LSB +: 3];
            n.clock_source_select  = hwdata[`IMCC_SCS_LSB +: 2]; // [RULE21]
         end
         else if (s.ahb_idx == IDX_AUX)
         begin
            n.secondary_osc_enable = hwdata[`IMCC_SEC_EN_BIT];
            n.wdt_enable           = hwdata[`IMCC_WDT_EN_BIT];
            n.fscm_enable          = hwdata[`IMCC_FSCM_EN_BIT];
         end
      end

      // fast internal oscillator stabilisation timer
      if (n.internal_freq_select == 3'h0)
      begin
         n.int_stable = 1'b0; // [RULE18]
         n.stable_cnt = 24'h0;
      end
      else if (!s.int_stable)
      begin
         if (s.stable_cnt == STABLE_LAST)
            n.int_stable = 1'b1; // [RULE16]
         else
            n.stable_cnt = s.stable_cnt + 24'h1;
      end

      // wake-up paths below never touch the control bits [RULE7]
      unique case (s.st)
         idle_mode_clock_controller_pkg::ST_RUN_PRI:
         begin
            n.cpu_clk_en    = 1'b1;
            n.periph_clk_en = 1'b1;
            if (wdt_timeout)
               n.wdt_reset = 1'b1;
            else if (sleep_instr)
            begin
               if (!s.idle_enable_bit && s.clock_source_select == 2'h0)
               begin
                  n.st                 = idle_mode_clock_controller_pkg::ST_SLEEP; // [RULE2]
                  n.cpu_clk_en         = 1'b0;
                  n.periph_clk_en      = 1'b0;
                  n.pri_osc_en         = 1'b0;
                  n.primary_ready_flag = 1'b0;
               end
               else if (s.idle_enable_bit && s.clock_source_select == 2'h0)
               begin
                  // primary stays up, flag stays set [RULE9]
                  n.st         = idle_mode_clock_controller_pkg::ST_IDLE; // [RULE1]
                  n.cpu_clk_en = 1'b0;
               end
               else if (s.idle_enable_bit && s.clock_source_select == 2'h1)
               begin
                  if (s.secondary_osc_enable) // [RULE12]
                  begin
                     n = begin_switch(n, idle_mode_clock_controller_pkg::SRC_SEC);
                     if (!s.sync2[4])
                        n.st = idle_mode_clock_controller_pkg::ST_SEC_WAIT; // [RULE13]
                  end
               end
               else if (s.idle_enable_bit)
                  n = begin_switch(n, idle_mode_clock_controller_pkg::SRC_INT); // [RULE15]
               // run-mode selections are not handled here and are ignored
            end
         end

         idle_mode_clock_controller_pkg::ST_SEC_WAIT:
         begin
            // peripheral clocks held off until the secondary oscillates
            if (s.sync2[4])
               n.st = idle_mode_clock_controller_pkg::ST_SWITCH; // [RULE13]
            else if (wake_event)
            begin
               n.st            = idle_mode_clock_controller_pkg::ST_RUN_PRI;
               n.cpu_clk_en    = 1'b1;
               n.periph_clk_en = 1'b1;
            end
         end

         idle_mode_clock_controller_pkg::ST_SWITCH:
         begin
            // count from an arbitrary phase: pause is 7 to 8 new-source periods
            if (osc_edge[s.target])
            begin
               n.edge_cnt = s.edge_cnt + 4'h1;
               if (s.edge_cnt == EDGE_LAST) // [RULE22]
               begin
                  n.src           = s.target;
                  n.periph_clk_en = 1'b1;
                  unique case (s.target)
                     idle_mode_clock_controller_pkg::SRC_PRI:
                     begin
                        n.st                    = idle_mode_clock_controller_pkg::ST_RUN_PRI;
                        n.cpu_clk_en            = 1'b1;
                        n.primary_ready_flag    = 1'b1; // [RULE6]
                        n.secondary_active_flag = 1'b0; // [RULE14]
                     end
                     idle_mode_clock_controller_pkg::SRC_SEC:
                     begin
                        n.st                    = idle_mode_clock_controller_pkg::ST_IDLE;
                        n.pri_osc_en            = 1'b0; // [RULE11]
                        n.primary_ready_flag    = 1'b0;
                        n.secondary_active_flag = 1'b1;
                     end
                     default:
                     begin
                        n.st                 = idle_mode_clock_controller_pkg::ST_IDLE;
                        n.pri_osc_en         = 1'b0; // [RULE15]
                        n.primary_ready_flag = 1'b0;
                     end
                  endcase
               end
            end
         end

         idle_mode_clock_controller_pkg::ST_IDLE:
         begin
            if (wake_event) // [RULE4] [RULE8]
            begin
               n.st       = idle_mode_clock_controller_pkg::ST_WAKE_DELAY;
               n.wait_cnt = 11'h0;
            end
         end

         idle_mode_clock_controller_pkg::ST_WAKE_DELAY:
         begin
            n.wait_cnt = s.wait_cnt + 11'h1;
            if (s.wait_cnt == WAKE_LAST) // [RULE5]
            begin
               n.cpu_clk_en = 1'b1;
               if (s.src == idle_mode_clock_controller_pkg::SRC_PRI)
                  n.st = idle_mode_clock_controller_pkg::ST_RUN_PRI; // [RULE10]
               else
               begin
                  // CPU on the idle source while primary warms up
                  n.st         = idle_mode_clock_controller_pkg::ST_RUN_ALT; // [RULE6]
                  n.pri_osc_en = 1'b1;
               end
            end
         end

         idle_mode_clock_controller_pkg::ST_RUN_ALT:
         begin
            if (s.sync2[3])
               n = begin_switch(n, idle_mode_clock_controller_pkg::SRC_PRI); // [RULE14] [RULE19]
         end

         idle_mode_clock_controller_pkg::ST_SLEEP:
         begin
            if (wake_event) // [RULE8]
            begin
               n.st         = idle_mode_clock_controller_pkg::ST_SLEEP_WAKE;
               n.pri_osc_en = 1'b1;
            end
         end

         idle_mode_clock_controller_pkg::ST_SLEEP_WAKE:
         begin
            if (s.sync2[3])
               n = begin_switch(n, idle_mode_clock_controller_pkg::SRC_PRI);
         end
      endcase

      // flag only while the fast oscillator drives the system [RULE17] [RULE19] [RULE23]
      n.internal_stable_flag = n.int_stable & (n.src == idle_mode_clock_controller_pkg::SRC_INT);
      n.fast_osc_en          = (n.internal_freq_select != 3'h0); // [RULE16] [RULE18]
      n.slow_osc_en          = n.wdt_enable | n.fscm_enable | // [RULE20]
                               ((n.src == idle_mode_clock_controller_pkg::SRC_INT) &
                                (n.internal_freq_select == 3'h0));

      // address phase; control and flag read data from next values so a write just before shows
      n.ahb_wr = addr_phase & hwrite;
      n.ready  = 1'b1;
      n.resp   = 1'b0;
      if (addr_phase)
      begin
         n.ahb_idx = haddr[7:2];
         n.rdata   = 32'h0;
         if (!hwrite && haddr[31:8] == 24'h0)
            n.rdata = read_word(n, s, haddr[7:2]);
      end
      else
         n.ahb_idx = 6'h3f;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s                      <= '0;
         s.idle_enable_bit      <= `IMCC_IDLE_RESET; // [RULE2]
         s.clock_source_select  <= `IMCC_SCS_RESET;
         s.internal_freq_select <= `IMCC_IFS_RESET;
         s.primary_ready_flag   <= 1'b1;
         s.cpu_clk_en           <= 1'b1;
         s.periph_clk_en        <= 1'b1;
         s.pri_osc_en           <= 1'b1;
         s.ready                <= 1'b1;
         s.ahb_idx              <= 6'h3f;
      end
      else if (clk_en)
         s <= n;
   end

   assign hreadyout            = s.ready;
   assign hresp                = s.resp;
   assign hrdata               = s.rdata;
   assign cpu_clk_en           = s.cpu_clk_en;
   assign periph_clk_en        = s.periph_clk_en;
   assign sys_clk_sel          = s.src;
   assign pri_osc_en           = s.pri_osc_en;
   assign fast_internal_osc_en = s.fast_osc_en;
   assign slow_internal_osc_en = s.slow_osc_en;
   assign wdt_reset            = s.wdt_reset;

endmodule : idle_mode_clock_controller

// File: testbench/idle_mode_clock_controller_asserts.sv
`timescale 1ns/10ps
module idle_mode_clock_controller_asserts (
   input wire logic       hclk,
   input wire logic       hresetn,
   input wire logic       hreadyout,
   input wire logic       hresp,
   input wire logic       wake_irq,
   input wire logic       wdt_timeout,
   input wire logic       cpu_clk_en,
   input wire logic       periph_clk_en,
   input wire logic [1:0] sys_clk_sel,
   input wire logic       pri_osc_en,
   input wire logic       wdt_reset
);
   // wake_seen: idle wake pending; wcnt times the cpu hold-off, plow the clock pause
   logic        wake_seen;
   logic [11:0] wcnt;
   logic [7:0]  plow;
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wake_seen <= 1'b0;
         wcnt      <= 12'h0;
         plow      <= 8'h0;
      end
      else
      begin
         wake_seen <= !cpu_clk_en && (wake_seen || (periph_clk_en && (wake_irq || wdt_timeout)));
         wcnt      <= wake_seen ? wcnt + 12'h1 : 12'h0;
         plow      <= periph_clk_en ? 8'h0 : plow + {7'h0, plow != 8'hff};
      end
   end
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("bus answer not zero-wait okay");
   cpu_periph_a: assert property (cpu_clk_en |-> periph_clk_en)
      else $error("cpu clocked while peripherals stopped");
   wdt_pulse_a: assert property (wdt_reset |-> $past(wdt_timeout) && $past(cpu_clk_en))
      else $error("watchdog reset without a time-out in run");
   wdt_wake_a: assert property (wdt_timeout && !cpu_clk_en |=> !wdt_reset)
      else $error("watchdog time-out in low power gave a reset");
   idle_hold_a: assert property (!cpu_clk_en && periph_clk_en && !wake_seen
      && !wake_irq && !wdt_timeout |=> !cpu_clk_en)
      else $error("idle left without a wake event");
   wake_delay_a: assert property ($rose(cpu_clk_en) && wake_seen
      |-> wcnt >= 12'd1250 && wcnt <= 12'd1251)
      else $error("cpu hold-off after wake has wrong length");
   alt_idle_a: assert property (sys_clk_sel != 2'h0 && periph_clk_en && !cpu_clk_en
      |-> !pri_osc_en)
      else $error("primary oscillator left on in alternate idle");
   all_off_a: assert property (!cpu_clk_en && !periph_clk_en && !pri_osc_en
      |-> sys_clk_sel == 2'h0)
      else $error("full sleep entered from a non-primary source");
   sel_switch_a: assert property ($changed(sys_clk_sel) |-> !$past(periph_clk_en))
      else $error("source changed without a clock pause");
   pause_len_a: assert property ($rose(periph_clk_en) |-> plow >= 8'd14)
      else $error("clock pause too short for eight source edges");
   cover property (wake_seen ##1 cpu_clk_en);
   cover property ($changed(sys_clk_sel) && sys_clk_sel == 2'h1);
   cover property ($changed(sys_clk_sel) && sys_clk_sel == 2'h2);
endmodule : idle_mode_clock_controller_asserts

bind idle_mode_clock_controller idle_mode_clock_controller_asserts i_asserts (
   .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
   .wake_irq(wake_irq), .wdt_timeout(wdt_timeout), .cpu_clk_en(cpu_clk_en),
   .periph_clk_en(periph_clk_en), .sys_clk_sel(sys_clk_sel), .pri_osc_en(pri_osc_en),
   .wdt_reset(wdt_reset));

// File: testbench/idle_mode_clock_controller_tb.sv
`timescale 1ns/10ps
`include "idle_mode_clock_controller_cfg.svh"
module idle_mode_clock_controller_tb;
   localparam logic [7:0] OSC  = `IMCC_OSC_CTRL_OFS;
   localparam logic [7:0] AUX  = `IMCC_AUX_CTRL_OFS;
   localparam int         WAKE = 1250;
   logic        hclk, hresetn, clk_en, hsel, hwrite, hready, hresp, wdt_reset;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans, sys_clk_sel;
   logic [2:0]  hsize, ev;
   logic        pri_osc_clk, sec_osc_clk, int_osc_clk, pri_ready_pin, sec_running_pin;
   logic        cpu_clk_en, periph_clk_en, pri_osc_en, fast_osc_en, slow_osc_en;
   logic [7:0]  pri_cnt;
   int          miscompares, n_checks;
   idle_mode_clock_controller #(.INT_STABLE_CYCLES(20)) i_idle_mode_clock_controller (
      .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .sleep_instr(ev[0]),
      .wake_irq(ev[1]), .wdt_timeout(ev[2]), .pri_osc_clk(pri_osc_clk),
      .sec_osc_clk(sec_osc_clk), .int_osc_clk(int_osc_clk), .pri_ready_pin(pri_ready_pin),
      .sec_running_pin(sec_running_pin), .cpu_clk_en(cpu_clk_en),
      .periph_clk_en(periph_clk_en), .sys_clk_sel(sys_clk_sel), .pri_osc_en(pri_osc_en),
      .fast_internal_osc_en(fast_osc_en), .slow_internal_osc_en(slow_osc_en),
      .wdt_reset(wdt_reset));
   initial
   begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   // oscillator periods not multiples of hclk so phases drift
   always #33 pri_osc_clk = ~pri_osc_clk;
   always #47 sec_osc_clk = ~sec_osc_clk;
   always #41 int_osc_clk = ~int_osc_clk;
   // primary reports ready 256 cycles after being enabled
   always @(posedge hclk)
   begin
      pri_cnt       <= pri_osc_en ? pri_cnt + {7'h0, pri_cnt != 8'hff} : 8'h0;
      pri_ready_pin <= pri_cnt == 8'hff;
   end
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rdy;
      for (int i = 0; i < 40; i++)
      begin
         @(posedge hclk);
         if (hready === 1'b1)
            return;
      end
      miscompares++;
      final_report();
   endtask : rdy
   // w=1 writes d, w=0 reads and compares against d
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      rdy();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= w ? d : 32'h0;
      rdy();
      if (!w)
         chk(hrdata, d);
   endtask : bus
   task automatic fire(input int s);
      @(posedge hclk);
      ev <= 3'h1 << s;
      @(posedge hclk);
      ev <= 3'h0;
   endtask : fire
   // s: 0 cpu clock, 1 peripheral clock, 2 source back on primary
   task automatic wait_o(input int s, input logic v, output int n);
      for (n = 0; n < 5000; n++)
      begin
         @(negedge hclk);
         if ((s == 0 ? cpu_clk_en : s == 1 ? periph_clk_en : sys_clk_sel == 2'h0) === v)
            return;
      end
      miscompares++;
      final_report();
   endtask : wait_o
   task automatic t_reset;
      @(negedge hclk);
      chk({cpu_clk_en, periph_clk_en, pri_osc_en, fast_osc_en, slow_osc_en, wdt_reset,
           sys_clk_sel}, 32'he0);
      bus(0, OSC, 32'h08);
      bus(0, AUX, 32'h0);
      bus(0, 8'h40, 32'h0);
      bus(1, OSC, 32'h0f);
      bus(0, OSC, 32'h0b);
      repeat (50) @(negedge hclk);
      chk({cpu_clk_en, sys_clk_sel}, 32'h4);
      bus(1, OSC, 32'h0);
   endtask : t_reset
   task automatic t_sleep;
      int n;
      fire(0);
      @(negedge hclk);
      chk({cpu_clk_en, periph_clk_en, pri_osc_en}, 32'h0);
      repeat (1500) @(negedge hclk);
      chk({cpu_clk_en, periph_clk_en}, 32'h0);
      bus(0, OSC, 32'h0);
      fire(1);
      wait_o(0, 1'b1, n);
      chk(n > 256, 1'b1);
      bus(0, OSC, 32'h08);
   endtask : t_sleep
   task automatic t_primary_idle_mode;
      int n;
      fire(2);
      @(negedge hclk);
      chk(wdt_reset, 1'b1);
      bus(1, OSC, 32'h80);
      fire(0);
      @(negedge hclk);
      chk({cpu_clk_en, periph_clk_en, pri_osc_en, sys_clk_sel}, 32'hc);
      bus(0, OSC, 32'h88);
      fire(2);
      wait_o(0, 1'b1, n);
      chk(n >= WAKE - 1 && n <= WAKE + 2, 1'b1);
      chk({wdt_reset, sys_clk_sel}, 32'h0);
      bus(0, OSC, 32'h88);
   endtask : t_primary_idle_mode
   task automatic t_sec;
      int n;
      bus(1, AUX, 32'h0);
      bus(1, OSC, 32'h81);
      fire(0);
      repeat (5) @(negedge hclk);
      chk(cpu_clk_en, 1'b1);
      bus(1, AUX, 32'h1);
      fire(0);
      repeat (200) @(negedge hclk);
      chk({cpu_clk_en, periph_clk_en}, 32'h0);
      @(posedge hclk);
      sec_running_pin <= 1'b1;
      wait_o(1, 1'b1, n);
      chk({sys_clk_sel, pri_osc_en, cpu_clk_en}, 32'h4);
      bus(0, OSC, 32'h81);
      bus(0, AUX, 32'h3);
      fire(1);
      wait_o(0, 1'b1, n);
      chk(sys_clk_sel, 32'h1);
      wait_o(1, 1'b0, n);
      wait_o(1, 1'b1, n);
      chk(n >= 52 && n <= 80, 1'b1);
      chk({sys_clk_sel, cpu_clk_en}, 32'h1);
      bus(0, AUX, 32'h1);
      bus(0, OSC, 32'h89);
   endtask : t_sec
   // select 11: the lower select bit must not matter
   task automatic t_int(input logic [2:0] f);
      int          n;
      logic [31:0] o;
      o = {24'h0, 1'b1, f, 4'h3};
      bus(1, AUX, 32'h0);
      bus(1, OSC, o);
      repeat (30) @(negedge hclk);
      chk(fast_osc_en, f != 3'h0);
      fire(0);
      wait_o(1, 1'b1, n);
      chk({sys_clk_sel, pri_osc_en, slow_osc_en}, {2'h2, 1'b0, f == 3'h0});
      bus(0, OSC, o | {29'h0, f != 3'h0, 2'h0});
      bus(1, AUX, 32'h4);
      fire(1);
      wait_o(0, 1'b1, n);
      chk(sys_clk_sel, 32'h2);
      wait_o(2, 1'b1, n);
      chk({cpu_clk_en, periph_clk_en, slow_osc_en}, 32'h7);
      bus(0, OSC, o | 32'h8);
   endtask : t_int
   initial
   begin
      {hresetn, hsel, hwrite, ev, sec_running_pin, pri_ready_pin} = 8'h0;
      {pri_osc_clk, sec_osc_clk, int_osc_clk} = 3'h0;
      {clk_en, hsize, htrans, haddr, hwdata, pri_cnt} = {1'b1, 3'h2, 2'h0, 64'h0, 8'h0};
      miscompares = 0;
      n_checks    = 0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_sleep();
      t_primary_idle_mode();
      t_sec();
      t_int(3'h0);
      t_int(3'h5);
      final_report();
   end
endmodule : idle_mode_clock_controller_tb
